/* src/nvm_defs.svh */
`ifndef NVM_DEFS_SVH
`define NVM_DEFS_SVH

// memory geometry
`define NVM_ADDR_W      13
`define NVM_DATA_W      8
`define NVM_MEM_DEPTH   8192
`define NVM_ADDR_HI_W   5

// write path buffer
`define NVM_FIFO_DEPTH  32

// bit counting within one byte
`define NVM_LAST_BIT    4'h7
`define NVM_BYTE_BITS   4'h8

// reset values; bus pins idle high behind their pull-up, straps pulled low
`define NVM_ADDR_RST    13'h0000
`define NVM_PIN_RST     1'b1
`define NVM_STRAP_RST   4'h0

// bus timing: fastest clock period the pins may carry, in ns
`define NVM_SCL_MIN_PERIOD_NS 1000
`define NVM_REF_PERIOD_NS     4
`define NVM_SCL_MIN_CYCLES    (`NVM_SCL_MIN_PERIOD_NS / `NVM_REF_PERIOD_NS)

`endif

/* src/nvm_fifo.sv */
`timescale 1ns/100ps
module nvm_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic      clk,
  input wire logic      rst,
  // streams
  nvm_stream_if.snk     in_port,
  nvm_stream_if.src     out_port
);
  localparam int AW = $clog2(DEPTH);

  // depth must be a power of two: pointers wrap by overflow
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wptr_r;
  logic [AW:0]      wptr_nxt;
  logic [AW:0]      rptr_r;
  logic [AW:0]      rptr_nxt;
  logic             full;
  logic             empty;
  logic             do_push;
  logic             do_pop;

  always_comb begin
    empty    = (wptr_r == rptr_r);
    full     = (wptr_r[AW] != rptr_r[AW]) && (wptr_r[AW-1:0] == rptr_r[AW-1:0]);
    do_push  = in_port.valid && !full;
    do_pop   = out_port.ready && !empty;
    wptr_nxt = do_push ? wptr_r + 1'b1 : wptr_r;
    rptr_nxt = do_pop ? rptr_r + 1'b1 : rptr_r;
  end

  assign in_port.ready  = !full;
  assign out_port.valid = !empty;
  assign out_port.data  = mem_r[rptr_r[AW-1:0]];

  always_ff @(posedge clk) begin
    if (rst) begin
      wptr_r <= '0;
      rptr_r <= '0;
    end else begin
      wptr_r <= wptr_nxt;
      rptr_r <= rptr_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_r[wptr_r[AW-1:0]] <= in_port.data;
    end
  end

  chk_fifo_no_overrun: assert property (@(posedge clk) disable iff (rst)
    full |=> (wptr_r == $past(wptr_r)))
    else $error("fifo pointer moved while full");
endmodule : nvm_fifo

/* src/nvm_i2c_slave.sv */
// Functional notes
// - answer only when select bits match pins
// - unconnected select pins read as zero
// - sample on clock rise, drive on fall
// - data line only pulled low or released
// - write protect high blocks every write
// - unconnected write protect reads low
// - 13-bit address, top three bits ignored
// - commit each byte at once, never busy
// - works with serial clock up to 1 MHz
// - same behaviour at 100 and 400 kHz
// - address byte: type, select, direction bit
// - address increments per byte, wraps to zero
// - start or stop before bit eight aborts
// - reads continue while master acknowledges
`timescale 1ns/100ps
`include "nvm_defs.svh"
module nvm_i2c_slave #(
  parameter logic [3:0] TYPE_CODE  = 4'h5,  // arbitrary device type code
  parameter int         FIFO_DEPTH = `NVM_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // two-wire bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // straps
  input  wire logic [2:0] device_select_pins,
  input  wire logic       write_protect,
  // status
  output logic            bus_active
);
  localparam int WW = `NVM_ADDR_W + `NVM_DATA_W;

  // pin synchronisers: first stage feeds only the second
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic       scl_d_r;
  logic       sda_d_r;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1_r <= {`NVM_STRAP_RST, {2{`NVM_PIN_RST}}};  // idle level: no false edge
      sync2_r <= {`NVM_STRAP_RST, {2{`NVM_PIN_RST}}};
      scl_d_r <= `NVM_PIN_RST;
      sda_d_r <= `NVM_PIN_RST;
    end else begin
      sync1_r <= {device_select_pins, write_protect, sda_in, scl_in};
      sync2_r <= sync1_r;
      scl_d_r <= sync2_r[0];
      sda_d_r <= sync2_r[1];
    end
  end

  // floating straps are pulled low at the pad, so a missing drive reads 0
  wire logic       scl_s = sync2_r[0];
  wire logic       sda_s = sync2_r[1];
  wire logic       wp_s  = sync2_r[2];
  wire logic [2:0] sel_s = sync2_r[5:3];

  // edges found from the sampled clock; 250 cycles per bit at 1 MHz
  wire logic scl_rise = scl_s && !scl_d_r;
  wire logic scl_fall = !scl_s && scl_d_r;
  wire logic start_ev = scl_s && scl_d_r && sda_d_r && !sda_s;
  wire logic stop_ev  = scl_s && scl_d_r && !sda_d_r && sda_s;

  // protocol state
  nvm_pkg::nvm_state_type      state_r;
  nvm_pkg::nvm_state_type      state_nxt;
  nvm_pkg::nvm_state_type      after_r;
  nvm_pkg::nvm_state_type      after_nxt;
  logic [3:0]                  cnt_r;
  logic [3:0]                  cnt_nxt;
  logic [7:0]                  shreg_r;
  logic [7:0]                  shreg_nxt;
  logic [7:0]                  tx_r;
  logic [7:0]                  tx_nxt;
  logic [`NVM_ADDR_W-1:0]      addr_r;
  logic [`NVM_ADDR_W-1:0]      addr_nxt;
  logic [`NVM_ADDR_HI_W-1:0]   ahi_r;
  logic [`NVM_ADDR_HI_W-1:0]   ahi_nxt;
  logic                        oe_r;
  logic                        oe_nxt;
  logic                        sda_out_r;
  logic                        active_r;
  logic                        push;
  logic                        rd_load;
  logic                        addr_inc;

  // array and write buffer
  logic [`NVM_DATA_W-1:0] mem [`NVM_MEM_DEPTH];
  nvm_stream_if #(.W(WW)) wr_in ();
  nvm_stream_if #(.W(WW)) wr_out ();

  wire logic [7:0] rdata   = mem[addr_r];
  wire logic [7:0] byte_in = {shreg_r[6:0], sda_s};
  wire logic dev_match = (byte_in[7:4] == TYPE_CODE) && (byte_in[3:1] == sel_s);

  always_comb begin
    state_nxt = state_r;
    after_nxt = after_r;
    cnt_nxt   = cnt_r;
    shreg_nxt = shreg_r;
    tx_nxt    = tx_r;
    addr_nxt  = addr_r;
    ahi_nxt   = ahi_r;
    oe_nxt    = oe_r;
    push      = 1'b0;
    rd_load   = 1'b0;
    addr_inc  = 1'b0;
    // bus conditions win over everything and never touch the array
    if (start_ev) begin
      state_nxt = nvm_pkg::ST_DEV;
      cnt_nxt   = '0;
      oe_nxt    = 1'b0;
    end else if (stop_ev) begin
      state_nxt = nvm_pkg::ST_IDLE;
      oe_nxt    = 1'b0;
    end else begin
      case (state_r)
        nvm_pkg::ST_DEV, nvm_pkg::ST_AHI, nvm_pkg::ST_ALO, nvm_pkg::ST_WR: begin
          if (scl_rise) begin
            shreg_nxt = byte_in;
            cnt_nxt   = cnt_r + 4'h1;
            if (cnt_r == `NVM_LAST_BIT) begin
              state_nxt = nvm_pkg::ST_ACKW;
              cnt_nxt   = '0;
              case (state_r)
                nvm_pkg::ST_DEV: begin
                  if (!dev_match) begin
                    state_nxt = nvm_pkg::ST_IDLE;
                  end else if (byte_in[0]) begin
                    after_nxt = nvm_pkg::ST_RD;
                  end else begin
                    after_nxt = nvm_pkg::ST_AHI;
                  end
                end
                nvm_pkg::ST_AHI: begin
                  ahi_nxt   = byte_in[`NVM_ADDR_HI_W-1:0];
                  after_nxt = nvm_pkg::ST_ALO;
                end
                nvm_pkg::ST_ALO: begin
                  addr_nxt  = {ahi_r, byte_in};
                  after_nxt = nvm_pkg::ST_WR;
                end
                default: begin
                  after_nxt = nvm_pkg::ST_WR;
                  if (!wp_s && !wr_in.ready) begin
                    state_nxt = nvm_pkg::ST_IDLE;
                  end else begin
                    push     = !wp_s;
                    addr_inc = 1'b1;
                  end
                end
              endcase
            end
          end
        end
        nvm_pkg::ST_ACKW: begin
          if (scl_fall) begin
            oe_nxt    = 1'b1;
            state_nxt = nvm_pkg::ST_ACKD;
          end
        end
        nvm_pkg::ST_ACKD: begin
          if (scl_fall) begin
            oe_nxt    = 1'b0;
            state_nxt = after_r;
            rd_load   = (after_r == nvm_pkg::ST_RD);
          end
        end
        nvm_pkg::ST_RD: begin
          if (scl_fall) begin
            if (cnt_r == `NVM_BYTE_BITS) begin
              oe_nxt    = 1'b0;
              addr_inc  = 1'b1;
              cnt_nxt   = '0;
              state_nxt = nvm_pkg::ST_RACK;
            end else begin
              oe_nxt  = !tx_r[7];
              tx_nxt  = {tx_r[6:0], 1'b0};
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
        nvm_pkg::ST_RACK: begin
          if (scl_rise) begin
            state_nxt = sda_s ? nvm_pkg::ST_IDLE : nvm_pkg::ST_RLD;
          end
        end
        nvm_pkg::ST_RLD: begin
          rd_load = scl_fall;
        end
        default: begin
          state_nxt = nvm_pkg::ST_IDLE;
        end
      endcase
      if (rd_load) begin
        oe_nxt    = !rdata[7];
        tx_nxt    = {rdata[6:0], 1'b0};
        cnt_nxt   = 4'h1;
        state_nxt = nvm_pkg::ST_RD;
      end
      if (addr_inc) begin
        addr_nxt = addr_r + `NVM_ADDR_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r   <= nvm_pkg::ST_IDLE;
      after_r   <= nvm_pkg::ST_IDLE;
      cnt_r     <= '0;
      shreg_r   <= '0;
      tx_r      <= '0;
      addr_r    <= `NVM_ADDR_RST;
      ahi_r     <= '0;
      oe_r      <= 1'b0;
      sda_out_r <= 1'b0;
      active_r  <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      after_r   <= after_nxt;
      cnt_r     <= cnt_nxt;
      shreg_r   <= shreg_nxt;
      tx_r      <= tx_nxt;
      addr_r    <= addr_nxt;
      ahi_r     <= ahi_nxt;
      oe_r      <= oe_nxt;
      sda_out_r <= 1'b0;
      active_r  <= (state_nxt != nvm_pkg::ST_IDLE);
    end
  end

  assign sda_oe     = oe_r;
  assign sda_out    = sda_out_r;
  assign bus_active = active_r;

  // the buffer drains within a few cycles, far inside one bus bit
  wire nvm_pkg::nvm_wr_word_type drain_word = wr_out.data;
  assign wr_in.valid = push;
  assign wr_in.data  = nvm_pkg::nvm_wr_word_type'{addr: addr_r, data: byte_in};
  // drain stalls while a read byte is taken from the array
  assign wr_out.ready = !rd_load;

  nvm_fifo #(
    .WIDTH (WW),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .clk      (ref_clk),
    .rst      (rst),
    .in_port  (wr_in),
    .out_port (wr_out)
  );

  always_ff @(posedge ref_clk) begin
    if (wr_out.valid && wr_out.ready) begin
      mem[drain_word.addr] <= drain_word.data;
    end
  end

  // checks
  chk_line_low_only: assert property (@(posedge ref_clk) disable iff (rst)
    !sda_out_r)
    else $error("data line driven high");
  chk_oe_on_fall: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(oe_r) |-> $past(scl_fall) || $past(start_ev) || $past(stop_ev))
    else $error("data line changed away from clock fall");
  chk_unselected_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    state_r == nvm_pkg::ST_IDLE |-> !oe_r)
    else $error("line pulled while idle");
  chk_select_mismatch: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == nvm_pkg::ST_DEV && scl_rise && cnt_r == `NVM_LAST_BIT && !dev_match
     && !start_ev && !stop_ev) |=> state_r == nvm_pkg::ST_IDLE)
    else $error("answered a foreign address");
  chk_wp_blocks: assert property (@(posedge ref_clk) disable iff (rst)
    wr_in.valid |-> !wp_s)
    else $error("write queued under protect");
  chk_push_eighth_bit: assert property (@(posedge ref_clk) disable iff (rst)
    wr_in.valid |-> scl_rise && cnt_r == `NVM_LAST_BIT && state_r == nvm_pkg::ST_WR)
    else $error("write queued off the eighth bit");
  chk_commit_fast: assert property (@(posedge ref_clk) disable iff (rst)
    wr_in.valid |-> ##[1:8] (wr_out.valid && wr_out.ready))
    else $error("byte not committed promptly");
  chk_addr_step: assert property (@(posedge ref_clk) disable iff (rst)
    addr_inc |=> addr_r == $past(addr_r) + `NVM_ADDR_W'(1))
    else $error("address latch did not step");
  chk_read_nack_end: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == nvm_pkg::ST_RACK && scl_rise && sda_s && !start_ev && !stop_ev)
    |=> state_r == nvm_pkg::ST_IDLE ##1 !oe_r)
    else $error("read continued after no-acknowledge");
endmodule : nvm_i2c_slave

/* src/nvm_pkg.sv */
`include "nvm_defs.svh"
package nvm_pkg;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_DEV,
    ST_AHI,
    ST_ALO,
    ST_WR,
    ST_ACKW,
    ST_ACKD,
    ST_RD,
    ST_RACK,
    ST_RLD
  } nvm_state_type;

  typedef struct packed {
    logic [`NVM_ADDR_W-1:0] addr;
    logic [`NVM_DATA_W-1:0] data;
  } nvm_wr_word_type;

endpackage : nvm_pkg

/* src/nvm_stream_if.sv */
`timescale 1ns/100ps
interface nvm_stream_if #(
  parameter int W = 8
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : nvm_stream_if

/* verif/nvm_i2c_master_model.sv */
`timescale 1ns/100ps
module nvm_i2c_master_model (
  // clock
  input  wire logic       ref_clk,
  // bus
  output logic            scl,
  output logic            sda_drv,
  input  wire logic       sda_wire,
  // results
  output logic            ack_valid,
  output logic            ack_bit,
  output logic            rd_valid,
  output logic [7:0]      rd_byte
);
  // quarter bus period in ref_clk cycles; 63 keeps the bus at or under 1 MHz
  int q = 63;

  initial begin
    scl       = 1'b1;
    sda_drv   = 1'b1;
    ack_valid = 1'b0;
    ack_bit   = 1'b1;
    rd_valid  = 1'b0;
    rd_byte   = 8'h00;
  end

  task automatic tick();
    repeat (q) @(posedge ref_clk);
  endtask : tick

  // data moves only while the clock is low, sampled mid high
  task automatic bit_io(input logic b, output logic r);
    sda_drv <= b;
    tick();
    scl <= 1'b1;
    tick();
    r = sda_wire;
    tick();
    scl <= 1'b0;
    tick();
  endtask : bit_io

  task automatic start();
    sda_drv <= 1'b1;
    tick();
    scl <= 1'b1;
    tick();
    sda_drv <= 1'b0;
    tick();
    scl <= 1'b0;
    tick();
  endtask : start

  // clock then stands still high between frames
  task automatic stop();
    sda_drv <= 1'b0;
    tick();
    scl <= 1'b1;
    tick();
    sda_drv <= 1'b1;
    tick();
  endtask : stop

  // fewer than 8 bits leaves the byte cut short, no ack slot
  task automatic send(input logic [7:0] d, input int n);
    logic r;
    for (int i = 7; i > 7 - n; i--) bit_io(d[i], r);
    if (n == 8) begin
      bit_io(1'b1, r);
      ack_bit   <= r;
      ack_valid <= 1'b1;
      @(posedge ref_clk);
      ack_valid <= 1'b0;
    end
  endtask : send

  task automatic recv(input logic nack);
    logic [7:0] d;
    logic       r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(nack, r);
    rd_byte  <= d;
    rd_valid <= 1'b1;
    @(posedge ref_clk);
    rd_valid <= 1'b0;
  endtask : recv
endmodule : nvm_i2c_master_model

/* verif/nvm_i2c_slave_tb.sv */
`timescale 1ns/100ps
module nvm_i2c_slave_tb;
  localparam logic [3:0] TYPE  = 4'h5;  // arbitrary device type code
  localparam int         LIMIT = 98000;
  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic [2:0]  pins    = 3'h0;
  logic        wp      = 1'b0;
  logic        scl, sda_drv, sda_wire, sda_out, sda_oe, bus_active;
  logic        ack_valid, ack_bit, rd_valid;
  logic [7:0]  rd_byte;
  logic [7:0]  shadow [0:8191];
  logic [7:0]  exp_rd [$];
  logic        exp_ack [$];
  logic        exp_busy [$];
  logic [31:0] seed = 32'h0001_0229;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          cyc = 0;

  always #2 ref_clk = ~ref_clk;
  // pull-up: the wire is low if either party pulls it
  assign sda_wire = sda_drv & ~sda_oe;

  nvm_i2c_slave #(.TYPE_CODE(TYPE), .FIFO_DEPTH(32)) nvm_i2c_slave_i (
    .ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .device_select_pins(pins),
    .write_protect(wp), .bus_active(bus_active));

  nvm_i2c_master_model nvm_i2c_master_model_i (
    .ref_clk(ref_clk), .scl(scl), .sda_drv(sda_drv), .sda_wire(sda_wire),
    .ack_valid(ack_valid), .ack_bit(ack_bit), .rd_valid(rd_valid), .rd_byte(rd_byte));

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd

  task automatic fail(input string m);
    n_mismatch++;
    $display("unexpected at %0t: %s", $time, m);
  endtask : fail

  task automatic cmp_ack(input logic got);
    logic e;
    comparisons++;
    e = (exp_ack.size() != 0) ? exp_ack.pop_front() : 1'bx;
    if (got !== e) fail("acknowledge level");
  endtask : cmp_ack

  task automatic cmp_rd(input logic [7:0] got);
    logic [7:0] e;
    comparisons++;
    e = (exp_rd.size() != 0) ? exp_rd.pop_front() : 8'hxx;
    if (got !== e) fail("read data");
  endtask : cmp_rd

  task automatic cmp_pin(input logic got);
    comparisons++;
    if (got !== 1'b0) fail("data pin driven high");
  endtask : cmp_pin

  task automatic cmp_busy(input logic got);
    logic e;
    comparisons++;
    e = (exp_busy.size() != 0) ? exp_busy.pop_front() : 1'bx;
    if (got !== e) fail("bus activity flag");
  endtask : cmp_busy

  always @(posedge ref_clk) begin
    cyc++;
    if (ack_valid === 1'b1) cmp_ack(ack_bit);
    if (rd_valid === 1'b1) cmp_rd(rd_byte);
    if (ack_valid === 1'b1 || rd_valid === 1'b1) cmp_busy(bus_active);
    if (!rst) cmp_pin(sda_out);
    if (cyc == LIMIT) begin
      fail("timeout");
      end_sim();
    end
  end

  task automatic wr(input logic [7:0] d, input logic ea);
    exp_ack.push_back(ea);
    exp_busy.push_back(!ea);
    nvm_i2c_master_model_i.send(d, 8);
  endtask : wr

  task automatic rd(input logic [7:0] ed, input logic nack);
    exp_rd.push_back(ed);
    exp_busy.push_back(!nack);
    nvm_i2c_master_model_i.recv(nack);
  endtask : rd

  task automatic addr_phase(input logic [15:0] a);
    nvm_i2c_master_model_i.start();
    wr({TYPE, pins, 1'b0}, 1'b0);
    wr(a[15:8], 1'b0);
    wr(a[7:0], 1'b0);
  endtask : addr_phase

  task automatic wseq(input logic [15:0] a, input int n);
    logic [7:0]  d;
    logic [12:0] ad;
    addr_phase(a);
    for (int i = 0; i < n; i++) begin
      d  = rnd();
      ad = a[12:0] + 13'(i);
      wr(d, 1'b0);
      if (!wp) shadow[ad] = d;
    end
    nvm_i2c_master_model_i.stop();
  endtask : wseq

  // full = 0 reads from the latched address, a gives the expected latch
  task automatic rseq(input logic [15:0] a, input int n, input logic full);
    logic [12:0] ad;
    if (full) addr_phase(a);
    nvm_i2c_master_model_i.start();
    wr({TYPE, pins, 1'b1}, 1'b0);
    for (int i = 0; i < n; i++) begin
      ad = a[12:0] + 13'(i);
      rd(shadow[ad], i == n - 1);
    end
    nvm_i2c_master_model_i.stop();
  endtask : rseq

  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    wseq(16'hfffe, 4);
    wp <= 1'b1;
    wseq(16'h1ffe, 2);
    wp <= 1'b0;
    addr_phase(16'h1fff);
    nvm_i2c_master_model_i.send(rnd(), 5);
    nvm_i2c_master_model_i.stop();
    rseq(16'h1ffe, 3, 1'b1);
    nvm_i2c_master_model_i.q = 157;
    rseq(16'h0001, 1, 1'b0);
    nvm_i2c_master_model_i.q = 63;
    for (int i = 0; i < 8; i++) begin
      pins <= 3'(i);
      @(posedge ref_clk);
      nvm_i2c_master_model_i.start();
      wr({TYPE, 3'h5, 1'b0}, i != 5);
      nvm_i2c_master_model_i.stop();
    end
    nvm_i2c_master_model_i.start();
    wr({TYPE ^ 4'h1, pins, 1'b0}, 1'b1);
    nvm_i2c_master_model_i.stop();
    repeat (20) @(posedge ref_clk);
    if (exp_ack.size() + exp_rd.size() + exp_busy.size() != 0) fail("result missing");
    end_sim();
  end

  task automatic end_sim();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
endmodule : nvm_i2c_slave_tb
